// file: src/lcra_defs.svh
// Opcodes, field positions, timing counts and reset values of the logic unit
`ifndef LCRA_DEFS_SVH
`define LCRA_DEFS_SVH

`define LCRA_GRP_XOR 5'h15
`define LCRA_GRP_OR 5'h16
`define LCRA_GRP_CMP 5'h17
`define LCRA_SRC_MEM 3'h6
`define LCRA_OP_XOR_IMM 8'hee
`define LCRA_OP_OR_IMM 8'hf6
`define LCRA_OP_CMP_IMM 8'hfe
`define LCRA_OP_ROT_LC 8'h07
`define LCRA_OP_ROT_RC 8'h0f
`define LCRA_OP_ROT_LT 8'h17
`define LCRA_OP_ROT_RT 8'h1f
`define LCRA_OP_INV_ACC 8'h2f
`define LCRA_OP_INV_CY 8'h3f

`define LCRA_GRP_MSB 7
`define LCRA_GRP_LSB 3
`define LCRA_SRC_MSB 2

`define LCRA_ONE_CYCLE_STATES 3'h4
`define LCRA_TWO_CYCLE_STATES 3'h7

`define LCRA_ACC_RST 8'h00
`define LCRA_FLAG_RST 1'b0

`endif

// file: src/lcra_pkg.sv
// Types of the logic unit
package lcra_pkg;
  typedef enum logic [2:0] {
    LCRA_IDLE = 3'b001,
    LCRA_M1 = 3'b010,
    LCRA_M2 = 3'b100
  } lcra_state_t;

  typedef enum logic [3:0] {
    LCRA_C_XOR,
    LCRA_C_OR,
    LCRA_C_CMP,
    LCRA_C_RLC,
    LCRA_C_RRC,
    LCRA_C_RLT,
    LCRA_C_RRT,
    LCRA_C_INVA,
    LCRA_C_INVC,
    LCRA_C_NONE
  } lcra_class_t;
endpackage

// file: src/lcra_alu.sv
// Logic, compare and rotate unit of the accumulator datapath
`timescale 1ns/1ps
`include "lcra_defs.svh"

module lcra_alu (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic op_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] reg_data,
  input wire logic [15:0] hl_pair,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic acc_wr,
  input wire logic [7:0] acc_wr_data,
  output logic op_ready,
  output logic op_done,
  output logic op_bad,
  output logic [2:0] src_sel,
  output logic mem_rd_req,
  output logic imm_rd_req,
  output logic [15:0] mem_addr,
  output logic [7:0] acc,
  output logic zero_flag,
  output logic sign_flag,
  output logic parity_flag,
  output logic carry_flag,
  output logic auxiliary_carry_flag
);
  lcra_pkg::lcra_state_t state_r;
  lcra_pkg::lcra_class_t cls_r;
  logic [2:0] cnt_r;
  logic two_cyc_r;
  logic is_mem_r;
  logic have_r;
  logic [7:0] opnd_r;

  // Decode of the incoming opcode
  wire [4:0] grp = opcode[`LCRA_GRP_MSB:`LCRA_GRP_LSB];
  wire [2:0] src = opcode[`LCRA_SRC_MSB:0];
  wire is_xor_r = (grp == `LCRA_GRP_XOR);
  wire is_or_r = (grp == `LCRA_GRP_OR);
  wire is_cmp_r = (grp == `LCRA_GRP_CMP);
  wire is_regfam = is_xor_r | is_or_r | is_cmp_r;
  wire src_mem = is_regfam && (src == `LCRA_SRC_MEM);
  wire is_imm = (opcode == `LCRA_OP_XOR_IMM) | (opcode == `LCRA_OP_OR_IMM) |
                (opcode == `LCRA_OP_CMP_IMM);
  lcra_pkg::lcra_class_t dec_cls;
  always_comb begin
    dec_cls = lcra_pkg::LCRA_C_NONE;
    if (is_xor_r || opcode == `LCRA_OP_XOR_IMM)
      dec_cls = lcra_pkg::LCRA_C_XOR;
    else if (is_or_r || opcode == `LCRA_OP_OR_IMM)
      dec_cls = lcra_pkg::LCRA_C_OR;
    else if (is_cmp_r || opcode == `LCRA_OP_CMP_IMM)
      dec_cls = lcra_pkg::LCRA_C_CMP;
    else if (opcode == `LCRA_OP_ROT_LC)
      dec_cls = lcra_pkg::LCRA_C_RLC;
    else if (opcode == `LCRA_OP_ROT_RC)
      dec_cls = lcra_pkg::LCRA_C_RRC;
    else if (opcode == `LCRA_OP_ROT_LT)
      dec_cls = lcra_pkg::LCRA_C_RLT;
    else if (opcode == `LCRA_OP_ROT_RT)
      dec_cls = lcra_pkg::LCRA_C_RRT;
    else if (opcode == `LCRA_OP_INV_ACC)
      dec_cls = lcra_pkg::LCRA_C_INVA;
    else if (opcode == `LCRA_OP_INV_CY)
      dec_cls = lcra_pkg::LCRA_C_INVC;
  end

  wire idle = (state_r == lcra_pkg::LCRA_IDLE);
  wire take = idle && op_valid;
  wire legal = (dec_cls != lcra_pkg::LCRA_C_NONE);
  wire start = take && legal;
  wire dec_two = src_mem | is_imm;

  // Sequencing of states
  wire m1_end = (state_r == lcra_pkg::LCRA_M1) && (cnt_r == `LCRA_ONE_CYCLE_STATES);
  wire cap = (state_r == lcra_pkg::LCRA_M2) && !have_r && byte_valid;
  wire m2_end = (state_r == lcra_pkg::LCRA_M2) && have_r &&
                (cnt_r == `LCRA_TWO_CYCLE_STATES);
  wire exec = (m1_end && !two_cyc_r) || m2_end;

  lcra_pkg::lcra_state_t state_nxt;
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      lcra_pkg::LCRA_IDLE: begin
        if (start)
          state_nxt = lcra_pkg::LCRA_M1;
      end
      lcra_pkg::LCRA_M1: begin
        if (m1_end)
          state_nxt = two_cyc_r ? lcra_pkg::LCRA_M2 : lcra_pkg::LCRA_IDLE;
      end
      lcra_pkg::LCRA_M2: begin
        if (m2_end)
          state_nxt = lcra_pkg::LCRA_IDLE;
      end
      default: state_nxt = lcra_pkg::LCRA_IDLE;
    endcase
  end

  // Stretched at the seventh state while the byte is late
  wire [2:0] cnt_nxt = start ? 3'h1 :
                       (!idle && cnt_r != `LCRA_TWO_CYCLE_STATES) ? cnt_r + 3'h1 : cnt_r;

  // Operation results
  wire [7:0] a = acc;
  wire [7:0] b = opnd_r;
  wire [7:0] nb = ~b;
  wire [8:0] diff = {1'b0, a} + {1'b0, nb} + 9'h001;
  wire [4:0] ldiff = {1'b0, a[3:0]} + {1'b0, nb[3:0]} + 5'h01;
  wire [7:0] xor_res = a ^ b;
  wire [7:0] or_res = a | b;
  wire cmp_lt = !diff[8];

  logic [7:0] res;
  logic [7:0] acc_nxt;
  logic cy_nxt;
  logic ac_nxt;
  logic upd_zsp;
  always_comb begin
    res = a;
    acc_nxt = a;
    cy_nxt = carry_flag;
    ac_nxt = auxiliary_carry_flag;
    upd_zsp = 1'b0;
    unique case (cls_r)
      lcra_pkg::LCRA_C_XOR: begin
        res = xor_res;
        acc_nxt = xor_res;
        cy_nxt = 1'b0;
        ac_nxt = 1'b0;
        upd_zsp = 1'b1;
      end
      lcra_pkg::LCRA_C_OR: begin
        res = or_res;
        acc_nxt = or_res;
        cy_nxt = 1'b0;
        ac_nxt = 1'b0;
        upd_zsp = 1'b1;
      end
      lcra_pkg::LCRA_C_CMP: begin
        res = diff[7:0];
        cy_nxt = cmp_lt;
        ac_nxt = ldiff[4];
        upd_zsp = 1'b1;
      end
      lcra_pkg::LCRA_C_RLC: begin
        acc_nxt = {a[6:0], a[7]};
        cy_nxt = a[7];
      end
      lcra_pkg::LCRA_C_RRC: begin
        acc_nxt = {a[0], a[7:1]};
        cy_nxt = a[0];
      end
      lcra_pkg::LCRA_C_RLT: begin
        acc_nxt = {a[6:0], carry_flag};
        cy_nxt = a[7];
      end
      lcra_pkg::LCRA_C_RRT: begin
        acc_nxt = {carry_flag, a[7:1]};
        cy_nxt = a[0];
      end
      lcra_pkg::LCRA_C_INVA: acc_nxt = ~a;
      lcra_pkg::LCRA_C_INVC: cy_nxt = ~carry_flag;
      lcra_pkg::LCRA_C_NONE: acc_nxt = a;
    endcase
  end

  wire z_nxt = upd_zsp ? (res == 8'h00) : zero_flag;
  wire s_nxt = upd_zsp ? res[7] : sign_flag;
  wire p_nxt = upd_zsp ? ~^res : parity_flag;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= lcra_pkg::LCRA_IDLE;
      cnt_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cls_r <= lcra_pkg::LCRA_C_NONE;
      two_cyc_r <= 1'b0;
      is_mem_r <= 1'b0;
      src_sel <= 3'h0;
      mem_addr <= 16'h0000;
    end else if (start) begin
      cls_r <= dec_cls;
      two_cyc_r <= dec_two;
      is_mem_r <= src_mem;
      src_sel <= src;
      mem_addr <= hl_pair;
    end
  end

  // Operand: register now, or the byte read in the second machine cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      opnd_r <= 8'h00;
      have_r <= 1'b0;
    end else begin
      if (start)
        opnd_r <= reg_data;
      else if (cap)
        opnd_r <= byte_data;
      if (start || m2_end)
        have_r <= 1'b0;
      else if (cap)
        have_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_rd_req <= 1'b0;
      imm_rd_req <= 1'b0;
    end else begin
      mem_rd_req <= (m1_end && two_cyc_r && is_mem_r) ||
                    (mem_rd_req && !cap);
      imm_rd_req <= (m1_end && two_cyc_r && !is_mem_r) ||
                    (imm_rd_req && !cap);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_ready <= 1'b0;
      op_done <= 1'b0;
      op_bad <= 1'b0;
    end else begin
      op_ready <= (state_nxt == lcra_pkg::LCRA_IDLE);
      op_done <= exec;
      op_bad <= take && !legal;
    end
  end

  wire acc_load = idle && acc_wr;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc <= `LCRA_ACC_RST;
    end else if (exec) begin
      acc <= acc_nxt;
    end else if (acc_load) begin
      acc <= acc_wr_data;
    end
  end

  // Flags load only at the execute edge
  lcra_flag_bit #(.RST_VAL(`LCRA_FLAG_RST)) u_zero (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(exec),
    .d(z_nxt),
    .q(zero_flag)
  );
  lcra_flag_bit #(.RST_VAL(`LCRA_FLAG_RST)) u_sign (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(exec),
    .d(s_nxt),
    .q(sign_flag)
  );
  lcra_flag_bit #(.RST_VAL(`LCRA_FLAG_RST)) u_parity (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(exec),
    .d(p_nxt),
    .q(parity_flag)
  );
  lcra_flag_bit #(.RST_VAL(`LCRA_FLAG_RST)) u_carry (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(exec),
    .d(cy_nxt),
    .q(carry_flag)
  );
  lcra_flag_bit #(.RST_VAL(`LCRA_FLAG_RST)) u_aux (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(exec),
    .d(ac_nxt),
    .q(auxiliary_carry_flag)
  );
endmodule

// One condition flag, loaded when an operation executes
module lcra_flag_bit #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic d,
  output logic q
);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= RST_VAL;
    end else if (load) begin
      q <= d;
    end
  end
endmodule

// file: test/lcra_asserts.sv
// Checker of timing and flag effects of the logic unit
`timescale 1ns/1ps
module lcra_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic op_valid,
  input wire logic [7:0] opcode,
  input wire logic [15:0] hl_pair,
  input wire logic op_ready,
  input wire logic op_done,
  input wire logic mem_rd_req,
  input wire logic imm_rd_req,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] acc,
  input wire logic zero_flag,
  input wire logic sign_flag,
  input wire logic parity_flag,
  input wire logic carry_flag,
  input wire logic auxiliary_carry_flag
);
  logic [7:0] op_r;
  logic [7:0] acc_q;
  wire take = op_valid && op_ready;
  wire [4:0] grp = op_r[7:3];
  wire imm = opcode == 8'hee || opcode == 8'hf6 || opcode == 8'hfe;
  wire mem = opcode[2:0] == 3'h6 && opcode[7:3] >= 5'h15 && opcode[7:3] <= 5'h17;
  wire lgc = grp == 5'h15 || grp == 5'h16 || op_r == 8'hee || op_r == 8'hf6;
  wire cmp = grp == 5'h17 || op_r == 8'hfe;
  wire rot = op_r == 8'h07 || op_r == 8'h0f || op_r == 8'h17 || op_r == 8'h1f;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_r <= 8'h00;
      acc_q <= 8'h00;
    end else begin
      acc_q <= acc;
      if (take)
        op_r <= opcode;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  four_state_a: assert property (take && (opcode == 8'h07 || opcode == 8'hb1)
    |-> ##1 !op_done [*4] ##1 op_done) else $error("short op timing");
  seven_state_a: assert property (take && imm |-> ##1 !op_done [*7])
    else $error("long op too fast");
  imm_req_a: assert property (take && imm |-> ##5 imm_rd_req)
    else $error("no byte request");
  mem_req_a: assert property (take && mem
    |-> ##5 mem_rd_req && mem_addr == $past(hl_pair, 5)) else $error("memory request wrong");
  logic_clr_a: assert property (op_done && lgc |-> !carry_flag && !auxiliary_carry_flag)
    else $error("carry not cleared");
  res_flags_a: assert property (op_done && lgc |-> zero_flag == (acc == 8'h00)
    && sign_flag == acc[7] && parity_flag == ~^acc) else $error("result flags wrong");
  cmp_keep_a: assert property (op_done && cmp |-> acc == acc_q)
    else $error("compare changed acc");
  rot_left_a: assert property (op_done && op_r == 8'h07
    |-> acc == {acc_q[6:0], acc_q[7]} && carry_flag == acc_q[7]) else $error("rotate wrong");
  rot_keep_a: assert property (op_done && rot |-> $stable(zero_flag) && $stable(sign_flag)
    && $stable(parity_flag) && $stable(auxiliary_carry_flag)) else $error("rotate hit flags");
  inv_acc_a: assert property (op_done && op_r == 8'h2f
    |-> acc == ~acc_q && $stable(carry_flag)) else $error("acc invert wrong");
  inv_cy_a: assert property (op_done && op_r == 8'h3f
    |-> carry_flag != $past(carry_flag) && acc == acc_q) else $error("carry invert wrong");
endmodule
bind lcra_alu lcra_asserts u_chk (
  .clk(clk),
  .sys_rst(sys_rst),
  .op_valid(op_valid),
  .opcode(opcode),
  .hl_pair(hl_pair),
  .op_ready(op_ready),
  .op_done(op_done),
  .mem_rd_req(mem_rd_req),
  .imm_rd_req(imm_rd_req),
  .mem_addr(mem_addr),
  .acc(acc),
  .zero_flag(zero_flag),
  .sign_flag(sign_flag),
  .parity_flag(parity_flag),
  .carry_flag(carry_flag),
  .auxiliary_carry_flag(auxiliary_carry_flag)
);

// file: test/lcra_src_model.sv
// Far-side byte source answering memory and immediate reads
`timescale 1ns/1ps
module lcra_src_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic mem_rd_req,
  input wire logic imm_rd_req,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] imm_val,
  input wire logic [3:0] dly,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  logic [3:0] wait_r;
  logic [7:0] junk_r;
  wire req = mem_rd_req || imm_rd_req;
  // Memory content is a fixed function of the address
  wire [7:0] val = mem_rd_req ? mem_addr[7:0] ^ 8'h5a : imm_val;
  assign byte_valid = req && wait_r >= dly;
  assign byte_data = byte_valid ? val : junk_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_r <= 4'h0;
      junk_r <= 8'h00;
    end else begin
      junk_r <= ~byte_data;
      wait_r <= (byte_valid || !req) ? 4'h0 : wait_r + 4'h1;
    end
  end
endmodule

// file: test/tb_top.sv
// Self-checking bench of the logic unit
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin n_errors++; \
  $display("BAD %s exp %h got %h", nm, ex, gt); end end
module tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic op_valid = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic [7:0] reg_data = 8'h00;
  logic [15:0] hl_pair = 16'h0000;
  logic acc_wr = 1'b0;
  logic [7:0] acc_wr_data = 8'h00;
  logic [3:0] dly = 4'h0;
  logic byte_valid, op_ready, op_done, op_bad, mem_rd_req, imm_rd_req;
  logic [2:0] src_sel;
  logic [7:0] byte_data, acc;
  logic [15:0] mem_addr;
  logic zero_flag, sign_flag, parity_flag, carry_flag, auxiliary_carry_flag;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  lcra_alu u_dut (
    .clk(clk),
    .sys_rst(sys_rst),
    .op_valid(op_valid),
    .opcode(opcode),
    .reg_data(reg_data),
    .hl_pair(hl_pair),
    .byte_valid(byte_valid),
    .byte_data(byte_data),
    .acc_wr(acc_wr),
    .acc_wr_data(acc_wr_data),
    .op_ready(op_ready),
    .op_done(op_done),
    .op_bad(op_bad),
    .src_sel(src_sel),
    .mem_rd_req(mem_rd_req),
    .imm_rd_req(imm_rd_req),
    .mem_addr(mem_addr),
    .acc(acc),
    .zero_flag(zero_flag),
    .sign_flag(sign_flag),
    .parity_flag(parity_flag),
    .carry_flag(carry_flag),
    .auxiliary_carry_flag(auxiliary_carry_flag)
  );
  lcra_src_model u_src (
    .clk(clk),
    .sys_rst(sys_rst),
    .mem_rd_req(mem_rd_req),
    .imm_rd_req(imm_rd_req),
    .mem_addr(mem_addr),
    .imm_val(reg_data),
    .dly(dly),
    .byte_valid(byte_valid),
    .byte_data(byte_data)
  );
  task give_verdict;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Ceiling well above the under two hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      give_verdict;
    end
  end
  task run(input logic [7:0] op, r, input logic [15:0] hl, input logic [3:0] d, input int ec,
      input logic [7:0] ea, input logic [4:0] ef);
    int n;
    logic bad;
    n = 0;
    bad = 1'b0;
    while (op_ready !== 1'b1) @(posedge clk);
    op_valid <= 1'b1;
    opcode <= op;
    reg_data <= r;
    hl_pair <= hl;
    dly <= d;
    @(posedge clk);
    op_valid <= 1'b0;
    while (op_done !== 1'b1 && bad !== 1'b1 && n < 30) begin
      @(posedge clk);
      n++;
      bad = op_bad;
    end
    // Done shows one edge after the last state
    if (ec != 0) `CHK("cycles", ec, n - 1)
    `CHK("acc", ea, acc)
    `CHK("flags", ef, {zero_flag, sign_flag, parity_flag, carry_flag, auxiliary_carry_flag})
    `CHK("bad", op == 8'h80, bad)
    if (bad !== 1'b1) `CHK("src", op[2:0], src_sel)
    $display("test %h end", op);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    `CHK("ready in reset", 1'b0, op_ready)
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    acc_wr <= 1'b1;
    acc_wr_data <= 8'h96;
    @(posedge clk);
    acc_wr <= 1'b0;
    run(8'h3f, 8'h00, 16'h0000, 4'h0, 4, 8'h96, 5'b00010);
    run(8'h17, 8'h00, 16'h0000, 4'h0, 4, 8'h2d, 5'b00010);
    run(8'h0f, 8'h00, 16'h0000, 4'h0, 4, 8'h96, 5'b00010);
    run(8'h1f, 8'h00, 16'h0000, 4'h0, 4, 8'hcb, 5'b00000);
    run(8'h2f, 8'h00, 16'h0000, 4'h0, 4, 8'h34, 5'b00000);
    run(8'h3f, 8'h00, 16'h0000, 4'h0, 4, 8'h34, 5'b00010);
    run(8'hb1, 8'hc0, 16'h0000, 4'h0, 4, 8'hf4, 5'b01000);
    run(8'hae, 8'h00, 16'h1234, 4'h3, 0, 8'h9a, 5'b01100);
    run(8'hf6, 8'h05, 16'h0000, 4'h0, 7, 8'h9f, 5'b01100);
    run(8'hb6, 8'h00, 16'h00a5, 4'h2, 0, 8'hff, 5'b01100);
    run(8'hbf, 8'hff, 16'h0000, 4'h0, 4, 8'hff, 5'b10101);
    run(8'h2f, 8'h00, 16'h0000, 4'h0, 4, 8'h00, 5'b10101);
    run(8'hfe, 8'h01, 16'h0000, 4'h0, 7, 8'h00, 5'b01110);
    run(8'hbe, 8'h00, 16'h005a, 4'h1, 0, 8'h00, 5'b10101);
    run(8'h80, 8'h00, 16'h0000, 4'h0, 0, 8'h00, 5'b10101);
    run(8'ha8, 8'hbc, 16'h0000, 4'h0, 4, 8'hbc, 5'b01000);
    run(8'h07, 8'h00, 16'h0000, 4'h0, 4, 8'h79, 5'b01010);
    run(8'hee, 8'h0f, 16'h0000, 4'h0, 7, 8'h76, 5'b00000);
    give_verdict;
  end
endmodule
